// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb;
    import ucps_pkg::*;
    logic sys_clk_i = 1'h0, rst_i = 1'h1, tx_active_i = 1'h0, tx_bit_i = 1'h1;
    logic ir_active_i = 1'h0, ir_bit_i = 1'h0, modem_gpio_mode_i = 1'h0, req_send_i = 1'h0;
    logic term_ready_i = 1'h0, watchdog_expire_i = 1'h0, ref_clock_sel_i = 1'h0;
    logic cfg_wr_i = 1'h0, clear_send_ch0_n_i = 1'h1, set_ready_ch0_n_i = 1'h1;
    logic carrier_detect_ch0_n_i = 1'h1, ring_ind_ch0_n_i = 1'h1, rx_send = 1'h0;
    logic ir_send = 1'h0;
    logic [1:0] gpio_out_i = 2'h0, cfg_sel_i = 2'h0;
    logic [2:0] pull_down = 3'h0;
    logic [7:0] cfg_data_i = 8'h00;
    logic rx_bit_o, ir_rx_bit_o, ir_rx_busy_o, straps_valid_o, serial_out_ch0_o;
    logic serial_out_ch0_oe_n_o, infrared_out_n_o, watchdog_expired_n_o;
    logic watchdog_expired_n_oe_n_o, request_send_ch0_n_o, request_send_ch0_n_oe_n_o;
    logic terminal_ready_ch0_n_o, terminal_ready_ch0_n_oe_n_o, serial_in_ch0_i, infrared_in_n_i;
    wire serial_out_ch0_i, request_send_ch0_n_i, terminal_ready_ch0_n_i;
    logic [3:0] modem_status_o, gpio_in_o;
    logic [7:0] cfg_enable_o, cfg_base_hi_o, cfg_base_lo_o, cfg_irq_o, cfg_index_port_o;
    logic [31:0] ref_clock_hz_o;
    int mismatches = 0, check_count = 0, cycles = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    ucps_pins DUT (.*);
    ucps_far_end far_end (.pull_down_i(pull_down), .rx_send_i(rx_send), .ir_send_i(ir_send),
        .drv_i({terminal_ready_ch0_n_o, request_send_ch0_n_o, serial_out_ch0_o}),
        .oe_n_i({terminal_ready_ch0_n_oe_n_o, request_send_ch0_n_oe_n_o, serial_out_ch0_oe_n_o}),
        .pad_o({terminal_ready_ch0_n_i, request_send_ch0_n_i, serial_out_ch0_i}),
        .rx_pad_o(serial_in_ch0_i), .ir_pad_o(infrared_in_n_i));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp_v);
        check_count++;
        if (seen !== exp_v) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp_v, seen);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    // Writes during the capture and preset-load edges must be lost
    task automatic do_reset(input logic [2:0] pd);
        @(posedge sys_clk_i);
        rst_i <= 1'h1;
        pull_down <= pd;
        // Busy core inputs show that reset alone sets the line levels
        {tx_active_i, tx_bit_i, ir_active_i, ir_bit_i} <= 4'hB;
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk("reset_pins", {serial_out_ch0_o, infrared_out_n_o,
            serial_out_ch0_oe_n_o, request_send_ch0_n_oe_n_o,
            terminal_ready_ch0_n_oe_n_o, straps_valid_o}, 6'h2E);
        @(posedge sys_clk_i);
        rst_i <= 1'h0;
        {tx_active_i, tx_bit_i, ir_active_i, ir_bit_i} <= 4'h4;
        {cfg_wr_i, cfg_sel_i, cfg_data_i} <= {1'h1, UCPS_SEL_ENABLE, 8'h5A};
        repeat (2) @(posedge sys_clk_i);
        cfg_wr_i <= 1'h0;
        @(posedge sys_clk_i);
        #1;
    endtask : do_reset
    task automatic test_straps;
        logic tx_h, rts_h, dtr_h;
        logic [15:0] base;
        logic [31:0] preset;
        logic [7:0] index;
        for (int i = 0; i < 8; i++) begin
            do_reset(i[2:0]);
            {dtr_h, rts_h, tx_h} = ~i[2:0];
            base = tx_h ? {UCPS_BASE_HI_LEG, UCPS_BASE_LO_LEG} :
                          {UCPS_BASE_HI_ALT, UCPS_BASE_LO_ALT};
            preset = (tx_h || dtr_h) ? {UCPS_EN_ON, base, UCPS_IRQ_CH0} : 32'h0;
            index = rts_h ? UCPS_INDEX_DEF : UCPS_INDEX_ALT;
            chk("presets", {cfg_enable_o, cfg_base_hi_o,
                cfg_base_lo_o, cfg_irq_o}, preset);
            chk("driven", {serial_out_ch0_oe_n_o, request_send_ch0_n_oe_n_o,
                terminal_ready_ch0_n_oe_n_o, straps_valid_o}, 4'h1);
            chk("index", cfg_index_port_o, index);
            @(posedge sys_clk_i);
            pull_down <= ~pull_down;
            repeat (2) @(posedge sys_clk_i);
            #1;
            chk("index_held", cfg_index_port_o, index);
        end
        $display("strap test done");
    endtask : test_straps
    task automatic test_writes;
        @(posedge sys_clk_i);
        for (int s = 0; s < 4; s++) begin
            {cfg_wr_i, cfg_sel_i, cfg_data_i} <= {1'h1, s[1:0], 8'hC0 | s[7:0]};
            @(posedge sys_clk_i);
        end
        cfg_wr_i <= 1'h0;
        #1;
        chk("written", {cfg_enable_o, cfg_base_hi_o,
            cfg_base_lo_o, cfg_irq_o}, 32'hC0C1C2C3);
        $display("write test done");
    endtask : test_writes
    task automatic test_lines;
        logic [3:0] pat;
        @(posedge sys_clk_i);
        {tx_active_i, tx_bit_i, ir_active_i, ir_bit_i, watchdog_expire_i} <= 5'h17;
        {modem_gpio_mode_i, gpio_out_i, rx_send, ir_send, ref_clock_sel_i} <= 6'h2B;
        @(posedge sys_clk_i);
        #1;
        chk("busy", {serial_out_ch0_o, infrared_out_n_o,
            watchdog_expired_n_oe_n_o}, 3'h2);
        chk("wdt_low", watchdog_expired_n_o, 1'h0);
        chk("gpio", {terminal_ready_ch0_n_o, request_send_ch0_n_o}, 2'h1);
        chk("rx_a", {rx_bit_o, ir_rx_bit_o, ir_rx_busy_o}, 3'h7);
        chk("ref_48", ref_clock_hz_o, UCPS_REF_48M_HZ);
        @(posedge sys_clk_i);
        {tx_active_i, ir_active_i, watchdog_expire_i, modem_gpio_mode_i, req_send_i} <= 5'h01;
        {rx_send, ir_send, ref_clock_sel_i} <= 3'h4;
        @(posedge sys_clk_i);
        #1;
        chk("idle", {serial_out_ch0_o, infrared_out_n_o,
            watchdog_expired_n_oe_n_o}, 3'h5);
        chk("modem", {terminal_ready_ch0_n_o, request_send_ch0_n_o}, 2'h2);
        chk("rx_b", {rx_bit_o, ir_rx_bit_o, ir_rx_busy_o}, 3'h0);
        chk("ref_24", ref_clock_hz_o, UCPS_REF_24M_HZ);
        for (int b = 0; b < 4; b++) begin
            pat = ~(4'h1 << b);
            @(posedge sys_clk_i);
            {ring_ind_ch0_n_i, carrier_detect_ch0_n_i, set_ready_ch0_n_i, clear_send_ch0_n_i} <= pat;
            @(posedge sys_clk_i);
            #1;
            chk("status", {modem_status_o, gpio_in_o}, {~pat, pat});
        end
        $display("line test done");
    endtask : test_lines
    initial begin
        test_straps;
        test_writes;
        test_lines;
        stop_test;
    end
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 1000) begin
            mismatches++;
            stop_test;
        end
    end
endmodule : tb

// *** tb/ucps_far_end.sv ***
`timescale 1ns/10ps
module ucps_far_end (
    input wire logic [2:0] drv_i,
    input wire logic [2:0] oe_n_i,
    input wire logic [2:0] pull_down_i,
    input wire logic rx_send_i,
    input wire logic ir_send_i,
    output logic [2:0] pad_o,
    output logic rx_pad_o,
    output logic ir_pad_o
);
    // ==========
    // Strap pads {dtr, rts, tx}
    // Released pad rests on the pull-up unless a strap resistor pulls it down
    assign pad_o = (~oe_n_i & drv_i) | (oe_n_i & ~pull_down_i);
    // ==========
    // Remote senders
    assign rx_pad_o = !rx_send_i;
    assign ir_pad_o = ir_send_i;
endmodule : ucps_far_end

// *** tb/ucps_pins_checker.sv ***
`timescale 1ns/10ps
module ucps_pins_checker (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic tx_active_i,
    input wire logic serial_out_ch0_o,
    input wire logic ir_active_i,
    input wire logic infrared_out_n_o,
    input wire logic infrared_in_n_i,
    input wire logic ir_rx_busy_o,
    input wire logic watchdog_expire_i,
    input wire logic watchdog_expired_n_oe_n_o,
    input wire logic straps_valid_o,
    input wire logic [7:0] cfg_index_port_o,
    input wire logic cfg_wr_i,
    input wire logic [1:0] cfg_sel_i,
    input wire logic [7:0] cfg_data_i,
    input wire logic [7:0] cfg_base_hi_o,
    input wire logic ref_clock_sel_i,
    input wire logic [31:0] ref_clock_hz_o
);
    import ucps_pkg::*;
    // ==========
    // Properties
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // Depth two keeps clear of the writes refused just after reset
    sequence cfg_ready_s;
        straps_valid_o && $past(straps_valid_o, 2);
    endsequence
    sequence base_wr_s;
        cfg_wr_i && cfg_sel_i == UCPS_SEL_BASE_HI;
    endsequence
    tx_idle_a: assert property (!tx_active_i |=> serial_out_ch0_o)
        else $error("tx not idle high");
    ir_idle_a: assert property (!ir_active_i |=> !infrared_out_n_o)
        else $error("ir out not idle low");
    ir_quiet_a: assert property (!infrared_in_n_i |-> !ir_rx_busy_o)
        else $error("quiet ir seen as data");
    wdt_drive_a: assert property (!$past(rst_i) |->
        watchdog_expired_n_oe_n_o == !$past(watchdog_expire_i))
        else $error("watchdog drive wrong");
    index_hold_a: assert property ($past(straps_valid_o) |-> $stable(cfg_index_port_o))
        else $error("index moved");
    strap_load_a: assert property ($fell(rst_i) |-> ##2 straps_valid_o)
        else $error("straps late");
    base_wr_a: assert property (cfg_ready_s ##0 base_wr_s |=>
        cfg_base_hi_o == $past(cfg_data_i))
        else $error("base write lost");
    ref_rate_a: assert property (
        ref_clock_hz_o == (ref_clock_sel_i ? UCPS_REF_48M_HZ : UCPS_REF_24M_HZ))
        else $error("ref rate wrong");
endmodule : ucps_pins_checker
bind ucps_pins ucps_pins_checker u_chk (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .tx_active_i(tx_active_i),
    .serial_out_ch0_o(serial_out_ch0_o),
    .ir_active_i(ir_active_i),
    .infrared_out_n_o(infrared_out_n_o),
    .infrared_in_n_i(infrared_in_n_i),
    .ir_rx_busy_o(ir_rx_busy_o),
    .watchdog_expire_i(watchdog_expire_i),
    .watchdog_expired_n_oe_n_o(watchdog_expired_n_oe_n_o),
    .straps_valid_o(straps_valid_o),
    .cfg_index_port_o(cfg_index_port_o),
    .cfg_wr_i(cfg_wr_i),
    .cfg_sel_i(cfg_sel_i),
    .cfg_data_i(cfg_data_i),
    .cfg_base_hi_o(cfg_base_hi_o),
    .ref_clock_sel_i(ref_clock_sel_i),
    .ref_clock_hz_o(ref_clock_hz_o)
);

// *** verilog/ucps_pins.sv ***
// Functional notes
// - Serial transmit output stays high in reset and while idle.
// - Infrared transmit output stays low in reset and while idle.
// - Infrared receive rests low; steady low means no incoming data.
// - Strap pins sampled at reset to preset channel configuration values.
// - Strap presets remain writable by software afterwards.
// - Strap pins pulled up internally; unstrapped pin reads as one.
// - Watchdog expiry output is open drain, driven low only on expiry.
// - Modem status inputs active low, or read as general inputs.
// - Send request and terminal ready driven low when asserted, or GPIO.
// - Reference clock is 24 or 48 MHz; both supported.
// - Send request strap high selects index 0x2E, low selects 0x4E.
// - Both channel 0 base straps high give legacy base 0x3F8.
`timescale 1ns/10ps
module ucps_pins (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Core side of the channel
    input wire logic tx_active_i,
    input wire logic tx_bit_i,
    input wire logic ir_active_i,
    input wire logic ir_bit_i,
    output logic rx_bit_o,
    output logic ir_rx_bit_o,
    output logic ir_rx_busy_o,
    input wire logic modem_gpio_mode_i,
    input wire logic req_send_i,
    input wire logic term_ready_i,
    input wire logic [1:0] gpio_out_i,
    output logic [3:0] modem_status_o,
    output logic [3:0] gpio_in_o,
    input wire logic watchdog_expire_i,
    input wire logic ref_clock_sel_i,
    output logic [31:0] ref_clock_hz_o,
    input wire logic cfg_wr_i,
    input wire logic [1:0] cfg_sel_i,
    input wire logic [7:0] cfg_data_i,
    output logic [7:0] cfg_enable_o,
    output logic [7:0] cfg_base_hi_o,
    output logic [7:0] cfg_base_lo_o,
    output logic [7:0] cfg_irq_o,
    output logic [7:0] cfg_index_port_o,
    output logic straps_valid_o,
    // Line side pins
    output logic serial_out_ch0_o,
    output logic serial_out_ch0_oe_n_o,
    input wire logic serial_out_ch0_i,
    input wire logic serial_in_ch0_i,
    output logic infrared_out_n_o,
    input wire logic infrared_in_n_i,
    output logic request_send_ch0_n_o,
    output logic request_send_ch0_n_oe_n_o,
    input wire logic request_send_ch0_n_i,
    output logic terminal_ready_ch0_n_o,
    output logic terminal_ready_ch0_n_oe_n_o,
    input wire logic terminal_ready_ch0_n_i,
    input wire logic clear_send_ch0_n_i,
    input wire logic set_ready_ch0_n_i,
    input wire logic carrier_detect_ch0_n_i,
    input wire logic ring_ind_ch0_n_i,
    output logic watchdog_expired_n_o,
    output logic watchdog_expired_n_oe_n_o
);
    import ucps_pkg::*;

    // ==========================================================
    // Reset sequencing
    ucps_state_t state_reg;
    ucps_state_t state_next;
    wire logic capture;
    wire logic [3:0] strap_pins;
    wire logic [3:0] strap_q;

    // First cycle after release: pins still float on pull-ups
    assign capture = (state_reg == UCPS_ST_RESET);
    assign state_next = UCPS_ST_RUN;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= UCPS_ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Bit order: 3 port select, 2 alt base, 1 legacy base, 0 spare
    assign strap_pins = {request_send_ch0_n_i, terminal_ready_ch0_n_i,
                         serial_out_ch0_i, 1'b1};

    ucps_strap_latch u_latch (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .capture_i(capture),
        .strap_i(strap_pins),
        .strap_o(strap_q)
    );

    assign straps_valid_o = (state_reg == UCPS_ST_RUN);

    // ==========================================================
    // Strap decode into presets
    wire logic alt_base;
    wire logic legacy_base;
    wire logic any_base;
    wire logic [7:0] preset_en;
    wire logic [7:0] preset_hi;
    wire logic [7:0] preset_lo;
    wire logic [7:0] preset_irq;

    assign alt_base = strap_q[2];
    assign legacy_base = strap_q[1];
    assign any_base = alt_base | legacy_base;
    assign preset_en = any_base ? UCPS_EN_ON : UCPS_EN_OFF;
    // Legacy base wins when both straps are high
    assign preset_hi = legacy_base ? UCPS_BASE_HI_LEG :
                       (alt_base ? UCPS_BASE_HI_ALT : UCPS_ZERO);
    assign preset_lo = legacy_base ? UCPS_BASE_LO_LEG :
                       (alt_base ? UCPS_BASE_LO_ALT : UCPS_ZERO);
    assign preset_irq = any_base ? UCPS_IRQ_CH0 : UCPS_ZERO;
    assign cfg_index_port_o = strap_q[3] ? UCPS_INDEX_DEF : UCPS_INDEX_ALT;

    // ==========================================================
    // Preset configuration, software writable
    logic [7:0] en_reg;
    logic [7:0] hi_reg;
    logic [7:0] lo_reg;
    logic [7:0] irq_reg;
    logic capture_done_reg;
    wire logic wr_en;
    wire logic wr_hi;
    wire logic wr_lo;
    wire logic wr_irq;

    // Writes during the capture and preset-load cycles are dropped; preset lands first
    assign wr_en = cfg_wr_i & (cfg_sel_i == UCPS_SEL_ENABLE);
    assign wr_hi = cfg_wr_i & (cfg_sel_i == UCPS_SEL_BASE_HI);
    assign wr_lo = cfg_wr_i & (cfg_sel_i == UCPS_SEL_BASE_LO);
    assign wr_irq = cfg_wr_i & (cfg_sel_i == UCPS_SEL_IRQ);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            en_reg <= UCPS_ZERO;
            hi_reg <= UCPS_ZERO;
            lo_reg <= UCPS_ZERO;
            irq_reg <= UCPS_ZERO;
        end else if (state_reg == UCPS_ST_RESET) begin
            en_reg <= UCPS_ZERO;
            hi_reg <= UCPS_ZERO;
            lo_reg <= UCPS_ZERO;
            irq_reg <= UCPS_ZERO;
        end else if (capture_done_reg == 1'b0) begin
            en_reg <= preset_en;
            hi_reg <= preset_hi;
            lo_reg <= preset_lo;
            irq_reg <= preset_irq;
        end else begin
            if (wr_en) en_reg <= cfg_data_i;
            if (wr_hi) hi_reg <= cfg_data_i;
            if (wr_lo) lo_reg <= cfg_data_i;
            if (wr_irq) irq_reg <= cfg_data_i;
        end
    end

    // Marks that the latched straps have been copied into the presets
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            capture_done_reg <= 1'b0;
        end else if (state_reg == UCPS_ST_RUN) begin
            capture_done_reg <= 1'b1;
        end
    end

    assign cfg_enable_o = en_reg;
    assign cfg_base_hi_o = hi_reg;
    assign cfg_base_lo_o = lo_reg;
    assign cfg_irq_o = irq_reg;

    // ==========================================================
    // Line outputs, registered
    logic tx_reg;
    logic ir_reg;
    logic rts_reg;
    logic dtr_reg;
    logic wdt_reg;
    wire logic tx_next;
    wire logic ir_next;
    wire logic rts_next;
    wire logic dtr_next;

    assign tx_next = tx_active_i ? tx_bit_i : 1'b1;
    assign ir_next = ir_active_i ? ir_bit_i : 1'b0;
    assign rts_next = modem_gpio_mode_i ? gpio_out_i[0] : ~req_send_i;
    assign dtr_next = modem_gpio_mode_i ? gpio_out_i[1] : ~term_ready_i;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_reg <= 1'b1;
            ir_reg <= 1'b0;
            rts_reg <= 1'b1;
            dtr_reg <= 1'b1;
            wdt_reg <= 1'b0;
        end else begin
            tx_reg <= tx_next;
            ir_reg <= ir_next;
            rts_reg <= rts_next;
            dtr_reg <= dtr_next;
            wdt_reg <= watchdog_expire_i;
        end
    end

    // Strap pins released until capture so the pull-ups set the level
    assign serial_out_ch0_o = tx_reg;
    assign serial_out_ch0_oe_n_o = capture;
    assign request_send_ch0_n_o = rts_reg;
    assign request_send_ch0_n_oe_n_o = capture;
    assign terminal_ready_ch0_n_o = dtr_reg;
    assign terminal_ready_ch0_n_oe_n_o = capture;
    assign infrared_out_n_o = ir_reg;
    // Open drain: data always low, enable only on expiry
    assign watchdog_expired_n_o = 1'b0;
    assign watchdog_expired_n_oe_n_o = ~wdt_reg;

    // ==========================================================
    // Line inputs
    assign rx_bit_o = serial_in_ch0_i;
    assign ir_rx_bit_o = infrared_in_n_i;
    assign ir_rx_busy_o = infrared_in_n_i;
    assign modem_status_o = ~{ring_ind_ch0_n_i, carrier_detect_ch0_n_i,
                              set_ready_ch0_n_i, clear_send_ch0_n_i};
    assign gpio_in_o = {ring_ind_ch0_n_i, carrier_detect_ch0_n_i,
                        set_ready_ch0_n_i, clear_send_ch0_n_i};

    // ==========================================================
    // Reference clock rate for the baud divider
    assign ref_clock_hz_o = (ref_clock_sel_i == UCPS_REF_48M) ?
                            32'(UCPS_REF_48M_HZ) : 32'(UCPS_REF_24M_HZ);

endmodule : ucps_pins

// *** verilog/ucps_pkg.sv ***
package ucps_pkg;

    // ==========================================================
    // Strap presets for channel 0 (enable, base, interrupt)
    localparam logic [7:0] UCPS_EN_ON = 8'h01;
    localparam logic [7:0] UCPS_EN_OFF = 8'h00;
    localparam logic [7:0] UCPS_BASE_HI_ALT = 8'h03;
    localparam logic [7:0] UCPS_BASE_LO_ALT = 8'hE0;
    localparam logic [7:0] UCPS_BASE_HI_LEG = 8'h03;
    localparam logic [7:0] UCPS_BASE_LO_LEG = 8'hF8;
    localparam logic [7:0] UCPS_IRQ_CH0 = 8'h03;
    localparam logic [7:0] UCPS_ZERO = 8'h00;

    // ==========================================================
    // Configuration index port choices
    localparam logic [7:0] UCPS_INDEX_DEF = 8'h2E;
    localparam logic [7:0] UCPS_INDEX_ALT = 8'h4E;

    // ==========================================================
    // Reference clock selection codes
    localparam logic UCPS_REF_24M = 1'b0;
    localparam logic UCPS_REF_48M = 1'b1;
    localparam int UCPS_REF_24M_HZ = 24000000;
    localparam int UCPS_REF_48M_HZ = 48000000;

    // ==========================================================
    // Configuration write selectors
    localparam logic [1:0] UCPS_SEL_ENABLE = 2'h0;
    localparam logic [1:0] UCPS_SEL_BASE_HI = 2'h1;
    localparam logic [1:0] UCPS_SEL_BASE_LO = 2'h2;
    localparam logic [1:0] UCPS_SEL_IRQ = 2'h3;

    typedef enum logic [1:0] {
        UCPS_ST_RESET = 2'b01,
        UCPS_ST_RUN = 2'b10
    } ucps_state_t;

endpackage : ucps_pkg

// *** verilog/ucps_strap_latch.sv ***
`timescale 1ns/10ps
module ucps_strap_latch (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic capture_i,
    input wire logic [3:0] strap_i,
    output logic [3:0] strap_o
);
    import ucps_pkg::*;

    logic [3:0] strap_reg;

    // Reset constant is all ones, the level the internal pull-ups give
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_reg <= 4'hF;
        end else if (capture_i) begin
            strap_reg <= strap_i;
        end
    end

    assign strap_o = strap_reg;

endmodule : ucps_strap_latch
